// ---- pkg/wdog_pkg.sv ----
package wdog_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_SERVICE     = 8'h04;
   localparam logic [7:0]  OFS_CONFIG      = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h10;
   localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h14;
   localparam logic [7:0]  OFS_STATUS      = 8'h18;
   // Control register fields
   localparam int          BIT_WINDOW      = 7;
   localparam int          BIT_STOP_DBG    = 6;
   localparam int          BIT_WR_MASK     = 5;
   localparam int          RATE_LSB        = 0;
   localparam int          RATE_W          = 3;
   // Config register fields
   localparam int          BIT_CLK_SEL     = 0;
   localparam int          BIT_SPECIAL     = 1;
   // Interrupt status fields
   localparam int          IRQ_W           = 3;
   localparam int          EV_TIMEOUT      = 0;
   localparam int          EV_EARLY        = 1;
   localparam int          EV_RESTART      = 2;
   // Reset values
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [1:0]  CONFIG_RESET    = 2'h0;
   // Service keys
   localparam logic [7:0]  KEY_ARM         = 8'h55;
   localparam logic [7:0]  KEY_RESTART     = 8'hAA;
   // Time-out is 2^n watchdog clock ticks
   localparam int          CNT_W           = 25;
   localparam int          MAX_EXP         = 24;
   localparam logic [2:0]  RATE_OFF        = 3'h0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   function automatic logic [4:0] rate_exp(input logic [2:0] rate);
      case (rate)
         3'h1:    rate_exp = 5'h0E;
         3'h2:    rate_exp = 5'h10;
         3'h3:    rate_exp = 5'h12;
         3'h4:    rate_exp = 5'h14;
         3'h5:    rate_exp = 5'h16;
         3'h6:    rate_exp = 5'h17;
         default: rate_exp = 5'h18;
      endcase
   endfunction : rate_exp
endpackage : wdog_pkg

// ---- src/wdog_tick_sel.sv ----
`timescale 1ns/1ps
// Selects and edge-detects the watchdog clock source; inputs are
// synchronous levels toggling at the source rate.
module wdog_tick_sel (
   input  wire logic core_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic rc_clk_lvl_i,
   input  wire logic osc_clk_lvl_i,
   input  wire logic sel_i,
   output logic      tick_o
);
   logic src_q;
   logic next_src_q;
   logic next_tick;

   always_comb begin
      next_src_q = sel_i ? osc_clk_lvl_i : rc_clk_lvl_i;
      next_tick  = next_src_q & ~src_q;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         src_q  <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         src_q  <= next_src_q;
         tick_o <= next_tick;
      end
   end
endmodule : wdog_tick_sel

// ---- src/wdog_irq.sv ----
`timescale 1ns/1ps
// Sticky event status with enable; set beats a same-cycle clear.
module wdog_irq #(
   parameter int W = 3
) (
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] event_i,
   input  wire logic [W-1:0] clear_i,
   input  wire logic [W-1:0] enable_i,
   output logic      [W-1:0] status_o,
   output logic              irq_o
);
   logic [W-1:0] next_status;
   logic         next_irq;

   always_comb begin
      next_status = (status_o & ~clear_i) | event_i;
      next_irq    = |(next_status & enable_i);
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         status_o <= '0;
         irq_o    <= 1'b0;
      end else begin
         status_o <= next_status;
         irq_o    <= next_irq;
      end
   end
endmodule : wdog_irq

// ---- src/windowed_watchdog_control.sv ----
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module windowed_watchdog_control
   import wdog_pkg::*;
(
   input  wire logic                       core_clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic [wdog_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [wdog_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [wdog_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [wdog_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       internal_rc_clk_i,
   input  wire logic                       oscillator_clk_i,
   input  wire logic                       debug_mode_active_i,
   output logic                            periodic_run_o,
   output logic                            watchdog_reset_o,
   output logic                            irq_o
);
   import wdog_pkg::*;

   // Register state
   logic              window_mode_sel;
   logic              stop_in_debug;
   logic [RATE_W-1:0] timeout_rate_sel;
   logic              ctrl_written_once;
   logic              watchdog_clk_sel;
   logic              special_mode;
   logic [IRQ_W-1:0]  irq_enable;
   logic              next_window_mode_sel;
   logic              next_stop_in_debug;
   logic [RATE_W-1:0] next_timeout_rate_sel;
   logic              next_ctrl_written_once;
   logic              next_watchdog_clk_sel;
   logic              next_special_mode;
   logic [IRQ_W-1:0]  next_irq_enable;

   // Bus state
   logic [ADDR_W-1:0] aw_addr;
   logic              aw_held;
   logic [DATA_W-1:0] w_data;
   logic [3:0]        w_strb;
   logic              w_held;
   logic [ADDR_W-1:0] next_aw_addr;
   logic              next_aw_held;
   logic [DATA_W-1:0] next_w_data;
   logic [3:0]        next_w_strb;
   logic              next_w_held;
   logic              next_awready;
   logic              next_wready;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              next_arready;
   logic              next_rvalid;
   logic [1:0]        next_rresp;
   logic [DATA_W-1:0] next_rdata;

   // Counter state
   logic [CNT_W-1:0]  count;
   logic              armed;
   logic              wd_reset;
   logic [CNT_W-1:0]  next_count;
   logic              next_armed;
   logic              next_wd_reset;
   logic              next_periodic_run;

   logic              wd_tick;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_event;
   logic [IRQ_W-1:0]  irq_clear;

   logic              wr_fire;
   logic              wr_ctrl;
   logic              wr_service;
   logic [7:0]        wr_byte;
   logic              enabled;
   logic              halted;
   logic              forced_max;
   logic              eff_window;
   logic [4:0]        eff_exp;
   logic [CNT_W-1:0]  period;
   logic [CNT_W-1:0]  win_open;
   logic              in_window;
   logic              timeout_hit;
   logic              early_hit;
   logic              restart_hit;

   wdog_tick_sel u_tick (
      .core_clk_i    (core_clk_i),
      .sys_rst_i     (sys_rst_i),
      .rc_clk_lvl_i  (internal_rc_clk_i),
      .osc_clk_lvl_i (oscillator_clk_i),
      .sel_i         (watchdog_clk_sel),
      .tick_o        (wd_tick)
   );

   wdog_irq #(.W(IRQ_W)) u_irq (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .event_i    (irq_event),
      .clear_i    (irq_clear),
      .enable_i   (irq_enable),
      .status_o   (irq_status),
      .irq_o      (irq_o)
   );

   // Write channel: address and data taken in any order, one at a time
   always_comb begin
      next_aw_addr = aw_addr;
      next_aw_held = aw_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_w_held  = w_held;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_aw_held = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_w_held = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         case (aw_addr)
            OFS_CTRL, OFS_SERVICE, OFS_CONFIG,
            OFS_IRQ_CLEAR, OFS_IRQ_ENABLE: next_bresp = RESP_OKAY;
            default:                       next_bresp = RESP_SLVERR;
         endcase
      end
      next_awready = ~next_aw_held & ~next_bvalid;
      next_wready  = ~next_w_held & ~next_bvalid;
   end

   always_comb begin
      wr_fire    = aw_held & w_held & ~s_axi_bvalid;
      wr_byte    = w_data[7:0];
      wr_ctrl    = wr_fire && aw_addr == OFS_CTRL && w_strb[0];
      wr_service = wr_fire && aw_addr == OFS_SERVICE && w_strb[0];
      irq_clear  = '0;
      if (wr_fire && aw_addr == OFS_IRQ_CLEAR && w_strb[0]) begin
         irq_clear = w_data[IRQ_W-1:0];
      end
   end

   // Control and config registers
   always_comb begin
      next_window_mode_sel   = window_mode_sel;
      next_stop_in_debug     = stop_in_debug;
      next_timeout_rate_sel  = timeout_rate_sel;
      next_ctrl_written_once = ctrl_written_once;
      next_watchdog_clk_sel  = watchdog_clk_sel;
      next_special_mode      = special_mode;
      next_irq_enable        = irq_enable;
      if (wr_ctrl) begin
         next_stop_in_debug = wr_byte[BIT_STOP_DBG];
         // Rate and window are write-once in normal mode
         if (!wr_byte[BIT_WR_MASK]
             && (!ctrl_written_once || special_mode)) begin
            next_window_mode_sel   = wr_byte[BIT_WINDOW];
            next_timeout_rate_sel  = wr_byte[RATE_LSB +: RATE_W];
            next_ctrl_written_once = 1'b1;
         end
      end
      if (wr_fire && aw_addr == OFS_CONFIG && w_strb[0]) begin
         next_watchdog_clk_sel = w_data[BIT_CLK_SEL];
         next_special_mode     = w_data[BIT_SPECIAL];
      end
      if (wr_fire && aw_addr == OFS_IRQ_ENABLE && w_strb[0]) begin
         next_irq_enable = w_data[IRQ_W-1:0];
      end
   end

   // Effective period selection
   always_comb begin
      enabled    = timeout_rate_sel != RATE_OFF;
      halted     = stop_in_debug & debug_mode_active_i;
      forced_max = enabled & debug_mode_active_i
                   & ~stop_in_debug & special_mode;
      eff_window = window_mode_sel & ~forced_max;
      eff_exp    = forced_max ? 5'(MAX_EXP)
                              : rate_exp(timeout_rate_sel);
      period     = CNT_W'(1) << eff_exp;
      win_open   = period - (period >> 2);
      in_window  = count >= win_open;
      next_periodic_run = ~halted;
   end

   // Counter and service sequence
   always_comb begin
      next_count    = count;
      next_armed    = armed;
      next_wd_reset = wd_reset;
      timeout_hit   = 1'b0;
      early_hit     = 1'b0;
      restart_hit   = 1'b0;
      if (wr_ctrl && !wr_byte[BIT_WR_MASK]
          && (!ctrl_written_once || special_mode)) begin
         next_count = '0;
         next_armed = 1'b0;
      end else if (!enabled) begin
         next_count = '0;
         next_armed = 1'b0;
      end else begin
         if (wd_tick && !halted) begin
            next_count = count + CNT_W'(1);
         end
         if (next_count >= period) begin
            timeout_hit = 1'b1;
         end
         if (wr_service) begin
            if (eff_window && !in_window) begin
               early_hit = 1'b1;
            end else if (wr_byte == KEY_ARM) begin
               next_armed = 1'b1;
            end else if (wr_byte == KEY_RESTART && armed) begin
               next_count  = '0;
               next_armed  = 1'b0;
               restart_hit = 1'b1;
            end else begin
               next_armed = 1'b0;
            end
         end
         if (timeout_hit || early_hit) begin
            next_wd_reset = 1'b1;
            next_count    = '0;
            next_armed    = 1'b0;
         end
      end
      irq_event = '0;
      irq_event[EV_TIMEOUT] = timeout_hit;
      irq_event[EV_EARLY]   = early_hit;
      irq_event[EV_RESTART] = restart_hit;
   end

   // Read channel
   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = RESP_OKAY;
         next_rdata   = '0;
         case (s_axi_araddr)
            OFS_CTRL: begin
               // Write mask always reads zero
               next_rdata[BIT_WINDOW]            = window_mode_sel;
               next_rdata[BIT_STOP_DBG]          = stop_in_debug;
               next_rdata[RATE_LSB +: RATE_W]    = timeout_rate_sel;
            end
            OFS_SERVICE: next_rdata = '0;
            OFS_CONFIG: begin
               next_rdata[BIT_CLK_SEL] = watchdog_clk_sel;
               next_rdata[BIT_SPECIAL] = special_mode;
            end
            OFS_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
            OFS_IRQ_CLEAR:  next_rdata = '0;
            OFS_IRQ_ENABLE: next_rdata[IRQ_W-1:0] = irq_enable;
            OFS_STATUS:     next_rdata[CNT_W-1:0] = count;
            default:        next_rresp = RESP_SLVERR;
         endcase
      end
      // Raise ready again once reset has left both lines low
      if (!s_axi_arready && !s_axi_rvalid) begin
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         window_mode_sel   <= CTRL_RESET[BIT_WINDOW];
         stop_in_debug     <= CTRL_RESET[BIT_STOP_DBG];
         timeout_rate_sel  <= CTRL_RESET[RATE_LSB +: RATE_W];
         ctrl_written_once <= 1'b0;
         watchdog_clk_sel  <= CONFIG_RESET[BIT_CLK_SEL];
         special_mode      <= CONFIG_RESET[BIT_SPECIAL];
         irq_enable        <= '0;
         aw_addr           <= '0;
         aw_held           <= 1'b0;
         w_data            <= '0;
         w_strb            <= '0;
         w_held            <= 1'b0;
         s_axi_awready     <= 1'b0;
         s_axi_wready      <= 1'b0;
         s_axi_bvalid      <= 1'b0;
         s_axi_bresp       <= RESP_OKAY;
         s_axi_arready     <= 1'b0;
         s_axi_rvalid      <= 1'b0;
         s_axi_rresp       <= RESP_OKAY;
         s_axi_rdata       <= '0;
         count             <= '0;
         armed             <= 1'b0;
         wd_reset          <= 1'b0;
         watchdog_reset_o  <= 1'b0;
         periodic_run_o    <= 1'b0;
      end else begin
         window_mode_sel   <= next_window_mode_sel;
         stop_in_debug     <= next_stop_in_debug;
         timeout_rate_sel  <= next_timeout_rate_sel;
         ctrl_written_once <= next_ctrl_written_once;
         watchdog_clk_sel  <= next_watchdog_clk_sel;
         special_mode      <= next_special_mode;
         irq_enable        <= next_irq_enable;
         aw_addr           <= next_aw_addr;
         aw_held           <= next_aw_held;
         w_data            <= next_w_data;
         w_strb            <= next_w_strb;
         w_held            <= next_w_held;
         s_axi_awready     <= next_awready;
         s_axi_wready      <= next_wready;
         s_axi_bvalid      <= next_bvalid;
         s_axi_bresp       <= next_bresp;
         s_axi_arready     <= next_arready;
         s_axi_rvalid      <= next_rvalid;
         s_axi_rresp       <= next_rresp;
         s_axi_rdata       <= next_rdata;
         count             <= next_count;
         armed             <= next_armed;
         wd_reset          <= next_wd_reset;
         // Reset request stays up until the system reset clears the block
         watchdog_reset_o  <= next_wd_reset;
         periodic_run_o    <= next_periodic_run;
      end
   end
endmodule : windowed_watchdog_control

// ---- verif/wdog_ctrl_assertions.sv ----
`timescale 1ns/1ps
module wdog_ctrl_assertions
   import wdog_pkg::*;
(
   input wire logic                        core_clk_i,
   input wire logic                        sys_rst_i,
   input wire logic                        s_axi_awvalid,
   input wire logic                        s_axi_awready,
   input wire logic                        s_axi_wvalid,
   input wire logic                        s_axi_wready,
   input wire logic [1:0]                  s_axi_bresp,
   input wire logic                        s_axi_bvalid,
   input wire logic                        s_axi_bready,
   input wire logic [wdog_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic                        s_axi_arvalid,
   input wire logic                        s_axi_arready,
   input wire logic [wdog_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]                  s_axi_rresp,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_rready,
   input wire logic                        debug_mode_active_i,
   input wire logic                        periodic_run_o,
   input wire logic                        watchdog_reset_o,
   input wire logic                        irq_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_rst_sticky;
      watchdog_reset_o |=> watchdog_reset_o;
   endproperty
   a_rst_sticky: assert property (p_rst_sticky)
      else $error("system reset request dropped without reset");
   property p_rst_clear;
      $past(sys_rst_i) |-> !watchdog_reset_o && !irq_o;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("outputs not cleared by reset");
   property p_run_no_dbg;
      !$past(debug_mode_active_i) && !$past(sys_rst_i) |-> periodic_run_o;
   endproperty
   a_run_no_dbg: assert property (p_run_no_dbg)
      else $error("periodic counter halted outside debug");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write response late");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response not held");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data not held");
   property p_w_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_block: assert property (p_w_block)
      else $error("write taken while response pending");
   property p_r_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_block: assert property (p_r_block)
      else $error("read taken while data pending");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18 |=>
         s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");

   c_reset: cover property (watchdog_reset_o);
   c_irq: cover property (irq_o);
   c_halt: cover property (!periodic_run_o);
endmodule : wdog_ctrl_assertions

bind windowed_watchdog_control wdog_ctrl_assertions u_chk (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .debug_mode_active_i(debug_mode_active_i),
   .periodic_run_o(periodic_run_o),
   .watchdog_reset_o(watchdog_reset_o), .irq_o(irq_o));

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import wdog_pkg::*;
   localparam int TO_CYC = (1 << 14) * 2;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        rc = 1'h0, osc = 1'h0, dbg = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, prun, wrst, irq;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, d, c0;
   int          n_errors = 0, n_tests = 0, t0;

   always #12.5 clk = ~clk;
   // One watchdog tick every two core cycles keeps the long periods short
   always @(posedge clk) rc <= ~rc;
   always @(posedge clk) if (rc) osc <= ~osc;

   windowed_watchdog_control dut (
      .core_clk_i(clk), .sys_rst_i(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .internal_rc_clk_i(rc), .oscillator_clk_i(osc),
      .debug_mode_active_i(dbg), .periodic_run_o(prun),
      .watchdog_reset_o(wrst), .irq_o(irq));

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_ok = 1'h1;
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            w_ok = 1'h1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'h1);
      resp = bresp;
      bready <= 1'h0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge clk); while (rvalid !== 1'h1);
      d = rdata;
      resp = rresp;
      rready <= 1'h0;
      @(posedge clk);
   endtask : rd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic do_reset;
      rst <= 1'h1;
      dbg <= 1'h0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
   endtask : do_reset

   task automatic close_out;
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   initial begin
      // The tests need about 58000 cycles
      #(90000 * 25);
      n_errors++;
      close_out();
   end

   initial begin
      do_reset();
      rd(OFS_CTRL);
      chk(d, {24'h0, CTRL_RESET});
      rd(OFS_STATUS);
      chk(d, 32'h0);
      rd(8'h1C);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      chk(d, 32'h0);
      wr(8'h40, 32'h1);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      $display("test registers done");
      // Masked write must not use up the single control write
      wr(OFS_CTRL, 32'h22);
      rd(OFS_CTRL);
      chk(d, 32'h0);
      rd(OFS_STATUS);
      chk(d, 32'h0);
      wr(OFS_CTRL, 32'h01);
      rd(OFS_CTRL);
      chk(d, 32'h1);
      repeat (40) @(posedge clk);
      rd(OFS_STATUS);
      chk_bit(d != 32'h0, 1'h1);
      wr(OFS_IRQ_ENABLE, 32'h4);
      wr(OFS_SERVICE, {24'h0, KEY_ARM});
      wr(OFS_SERVICE, {24'h0, KEY_RESTART});
      rd(OFS_STATUS);
      chk_bit(d < 32'h10, 1'h1);
      chk_bit(irq, 1'h1);
      rd(OFS_IRQ_STATUS);
      chk(d, 32'h4);
      wr(OFS_IRQ_CLEAR, 32'h4);
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'h0);
      wr(OFS_CTRL, 32'h41);
      dbg <= 1'h1;
      repeat (3) @(posedge clk);
      chk_bit(prun, 1'h0);
      rd(OFS_STATUS);
      c0 = d;
      repeat (40) @(posedge clk);
      rd(OFS_STATUS);
      chk(d, c0);
      wr(OFS_CTRL, 32'h01);
      repeat (3) @(posedge clk);
      chk_bit(prun, 1'h1);
      repeat (40) @(posedge clk);
      rd(OFS_STATUS);
      chk_bit(d > c0, 1'h1);
      $display("test service and debug done");
      do_reset();
      wr(OFS_CTRL, 32'h01);
      t0 = 0;
      while (wrst !== 1'h1 && t0 < 40000) begin
         @(posedge clk);
         t0++;
      end
      chk_bit(t0 >= TO_CYC - 8 && t0 <= TO_CYC + 24, 1'h1);
      rd(OFS_IRQ_STATUS);
      chk_bit(d[EV_TIMEOUT], 1'h1);
      $display("test timeout done");
      do_reset();
      wr(OFS_CTRL, 32'h81);
      wr(OFS_SERVICE, {24'h0, KEY_ARM});
      repeat (4) @(posedge clk);
      chk_bit(wrst, 1'h1);
      rd(OFS_IRQ_STATUS);
      chk_bit(d[EV_EARLY], 1'h1);
      do_reset();
      wr(OFS_CTRL, 32'h81);
      c0 = 32'h0;
      while (c0 < (1 << 14) * 3 / 4 + 64) begin
         rd(OFS_STATUS);
         c0 = d;
      end
      wr(OFS_SERVICE, {24'h0, KEY_ARM});
      wr(OFS_SERVICE, {24'h0, KEY_ARM});
      wr(OFS_SERVICE, {24'h0, KEY_RESTART});
      chk_bit(wrst, 1'h0);
      rd(OFS_STATUS);
      chk_bit(d < 32'h40, 1'h1);
      wr(OFS_SERVICE, {24'h0, KEY_ARM});
      repeat (4) @(posedge clk);
      chk_bit(wrst, 1'h1);
      $display("test window done");
      do_reset();
      wr(OFS_CONFIG, 32'h2);
      wr(OFS_CTRL, 32'h81);
      dbg <= 1'h1;
      @(posedge clk);
      wr(OFS_SERVICE, {24'h0, KEY_ARM});
      wr(OFS_SERVICE, {24'h0, KEY_RESTART});
      repeat (4) @(posedge clk);
      chk_bit(wrst, 1'h0);
      rd(OFS_STATUS);
      chk_bit(d < 32'h40, 1'h1);
      $display("test special debug done");
      do_reset();
      wr(OFS_CONFIG, 32'h1);
      wr(OFS_CTRL, 32'h01);
      repeat (80) @(posedge clk);
      rd(OFS_STATUS);
      // Oscillator ticks every fourth cycle, half the RC rate
      chk_bit(d > 32'h10 && d < 32'h18, 1'h1);
      $display("test clock select done");
      close_out();
   end
endmodule : tb_top
